// ---- design/fos_pkg.sv ----
// Shared types and constants of the fragment output stage.
package fos_pkg;

	localparam int NUM_TARGETS = 4;
	localparam int NUM_OUTS    = 8;
	localparam int SLOT_W      = 3;
	localparam int OUT_IDX_W   = 3;
	localparam int COL_BITS    = 8;
	localparam int DEPTH_BITS  = 24;
	// Accumulation components hold at least the colour bits.
	localparam int ACC_BITS    = 2 * COL_BITS;
	localparam int CI_COV_BITS = 4;

	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_FMT   = 8'h04;
	localparam logic [7:0] REG_BIND  = 8'h08;
	localparam logic [7:0] REG_BUILD = 8'h0C;
	localparam logic [7:0] REG_QUERY = 8'h10;
	localparam logic [7:0] REG_COUNT = 8'h14;
	localparam logic [7:0] REG_FBSEL = 8'h18;

	localparam int CTRL_CLAMP = 0;
	localparam int CTRL_CI    = 1;
	localparam int CTRL_MS    = 2;
	localparam int CTRL_DFLT  = 3;
	localparam int BIND_SLOT  = 4;
	localparam int BIND_ACT   = 8;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
	localparam logic [31:0] FMT_RST   = 32'h0000_0000;
	localparam logic [31:0] FBSEL_RST = 32'h0000_0000;
	localparam logic [31:0] NO_SLOT   = 32'hFFFF_FFFF;

	localparam logic [31:0] FP_ONE    = 32'h3F80_0000;
	localparam logic [7:0]  FP_BIAS   = 8'h7F;
	localparam logic [7:0]  FP_INF_E  = 8'hFF;
	localparam logic [23:0] UMAX      = 24'h00_00FF;
	localparam logic [23:0] SMAX      = 24'h00_007F;
	localparam logic [23:0] DMAX      = 24'hFF_FFFF;
	localparam logic [8:0]  SCALE_ONE = 9'h100;

	// Colour buffer representation of one draw target.
	typedef enum logic [1:0] {FMT_UNORM, FMT_SNORM, FMT_FLOAT, FMT_INT}
		fos_fmt_e;

	// Which shader outputs feed the colour numbers.
	typedef enum logic [1:0] {SRC_FINAL, SRC_DATA, SRC_VARY} fos_src_e;

	typedef logic [3:0][31:0] fos_vec_t;

	// A pixel is one colour index or components in R, G, B, A order.
	typedef struct packed {
		logic [31:0]  index;
		fos_vec_t     rgba;
	} fos_pixel_s;

	// Colour, depth and stencil attachments, each may be absent.
	typedef struct packed {
		logic [NUM_TARGETS-1:0] colour_present;
		logic                   depth_present;
		logic                   stencil_present;
	} fos_attach_s;

	typedef struct packed {
		fos_vec_t [NUM_OUTS-1:0] col;
		logic [NUM_OUTS-1:0]     is_float;
		fos_src_e                src;
		logic                    depth_written;
		logic [31:0]             shader_depth;
		logic [31:0]             raster_depth;
		logic                    aa_en;
		logic [7:0]              coverage;
		logic                    is_point;
		logic [7:0]              fade;
		logic [31:0]             ci_index;
	} fos_frag_s;

	typedef struct packed {
		fos_vec_t [NUM_TARGETS-1:0] col;
		logic [31:0]                depth;
		logic [31:0]                ci_index;
	} fos_out_s;

endpackage : fos_pkg

// ---- design/fos_stage.sv ----
// Fragment output stage: clamp, convert, route and coverage of colours.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module fos_stage #(
	parameter int CI_BITS = fos_pkg::CI_COV_BITS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	input  wire logic              in_valid,
	input  wire fos_pkg::fos_frag_s in_frag,
	output logic                   in_ready,
	output logic                   out_valid,
	output fos_pkg::fos_out_s      out_frag,
	input  wire logic              out_ready
);

	// Clamp a float to [0,1]; a NaN becomes zero.
	function automatic logic [31:0] clamp01(input logic [31:0] x);
		logic [31:0] r;
		if (x[30:23] == fos_pkg::FP_INF_E && x[22:0] != 23'h0)
			r = 32'h0000_0000;
		else if (x[31])
			r = 32'h0000_0000;
		else if (x[30:23] >= fos_pkg::FP_BIAS)
			r = fos_pkg::FP_ONE;
		else
			r = x;
		return r;
	endfunction : clamp01

	// Non-negative float to a rounded fixed code of full scale mx.
	function automatic logic [31:0] f2fix(input logic [31:0] x,
		input logic [23:0] mx);
		logic [63:0] p;
		int          sh;
		logic [31:0] r;
		sh = 150 - int'(x[30:23]);
		p = 64'({1'b1, x[22:0]}) * 64'(mx);
		if (x[30:23] >= fos_pkg::FP_BIAS)
			r = 32'(mx);
		else if (x[30:23] == 8'h00 || sh > 62)
			r = 32'h0000_0000;
		else
			r = 32'((p + (64'h1 << (sh - 1))) >> sh);
		return r;
	endfunction : f2fix

	// Multiply a float by c/256, with c = 256 meaning exactly one.
	// Truncating the product keeps the logic small at a cost of up to one
	// ulp, which is far below what any fixed target can resolve.
	function automatic logic [31:0] fscale(input logic [31:0] x,
		input logic [8:0] c);
		logic [32:0] p;
		int          msb;
		int          e;
		logic [31:0] r;
		p = 33'({1'b1, x[22:0]}) * 33'(c);
		msb = 23;
		for (int i = 24; i < 33; i++)
			if (p[i])
				msb = i;
		e = int'(x[30:23]) + msb - 31;
		if (c[8])
			r = x;
		else if (c == 9'h000 || x[30:23] == 8'h00 || e <= 0)
			r = {x[31], 31'h0};
		else
			r = {x[31], e[7:0], 23'(p >> (msb - 23))};
		return r;
	endfunction : fscale

	// Software controls and the output binding tables.
	logic [31:0]                        ctrl_r;
	logic [31:0]                        fmt_r;
	logic [31:0]                        fbsel_r;
	logic [31:0]                        count_r;
	logic [31:0]                        rdata_r;
	logic [fos_pkg::OUT_IDX_W-1:0]      query_r;
	logic [fos_pkg::NUM_OUTS-1:0]       bind_act_r;
	logic [fos_pkg::NUM_OUTS-1:0]       live_act_r;
	logic [fos_pkg::NUM_OUTS-1:0][fos_pkg::SLOT_W-1:0] bind_slot_r;
	logic [fos_pkg::NUM_OUTS-1:0][fos_pkg::SLOT_W-1:0] live_slot_r;
	logic                               built_ok_r;
	logic                               build_fail_r;
	logic                               valid_r;
	logic                               ready_r;
	fos_pkg::fos_out_s                  out_r;

	wire logic wr_ctrl  = reg_wr && reg_addr == fos_pkg::REG_CTRL;
	wire logic wr_fmt   = reg_wr && reg_addr == fos_pkg::REG_FMT;
	wire logic wr_bind  = reg_wr && reg_addr == fos_pkg::REG_BIND;
	wire logic wr_build = reg_wr && reg_addr == fos_pkg::REG_BUILD;
	wire logic wr_query = reg_wr && reg_addr == fos_pkg::REG_QUERY;
	wire logic wr_fbsel = reg_wr && reg_addr == fos_pkg::REG_FBSEL;

	wire logic clamp_en = ctrl_r[fos_pkg::CTRL_CLAMP];
	wire logic ci_mode  = ctrl_r[fos_pkg::CTRL_CI];
	wire logic ms_en    = ctrl_r[fos_pkg::CTRL_MS];
	wire logic d_float  = ctrl_r[fos_pkg::CTRL_DFLT];

	wire logic [fos_pkg::OUT_IDX_W-1:0] bind_idx =
		reg_wdata[fos_pkg::OUT_IDX_W-1:0];

	// Build check: active outputs against the target count and aliasing.
	logic [4:0] act_count;
	logic       alias_hit;
	logic       range_hit;
	always_comb
	begin
		act_count = 5'h00;
		alias_hit = 1'b0;
		range_hit = 1'b0;
		for (int i = 0; i < fos_pkg::NUM_OUTS; i++)
		begin
			if (bind_act_r[i])
			begin
				act_count = act_count + 5'h01;
				if (int'(bind_slot_r[i]) >= fos_pkg::NUM_TARGETS)
					range_hit = 1'b1;
				for (int j = i + 1; j < fos_pkg::NUM_OUTS; j++)
					if (bind_act_r[j] && bind_slot_r[j] == bind_slot_r[i])
						alias_hit = 1'b1;
			end
		end
	end
	wire logic build_bad = int'(act_count) > fos_pkg::NUM_TARGETS
		|| alias_hit || range_hit;

	// Slot query answer; unbound names and unbuilt programs give -1.
	wire logic [31:0] query_res = (built_ok_r && live_act_r[query_r])
		? 32'(live_slot_r[query_r]) : fos_pkg::NO_SLOT;

	logic [31:0] rd_mux;
	always_comb
	begin
		unique case (reg_addr)
			fos_pkg::REG_CTRL:  rd_mux = ctrl_r;
			fos_pkg::REG_FMT:   rd_mux = fmt_r;
			fos_pkg::REG_BUILD: rd_mux = {30'h0, build_fail_r, built_ok_r};
			fos_pkg::REG_QUERY: rd_mux = query_res;
			fos_pkg::REG_COUNT: rd_mux = count_r;
			fos_pkg::REG_FBSEL: rd_mux = fbsel_r;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r  <= fos_pkg::CTRL_RST;
			fmt_r   <= fos_pkg::FMT_RST;
			fbsel_r <= fos_pkg::FBSEL_RST;
			query_r <= '0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata;
			if (wr_fmt)
				fmt_r <= reg_wdata;
			if (wr_fbsel)
				fbsel_r <= reg_wdata;
			if (wr_query)
				query_r <= bind_idx;
			rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Pending bindings only take effect at the next successful build.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bind_act_r   <= '0;
			bind_slot_r  <= '0;
			live_act_r   <= '0;
			live_slot_r  <= '0;
			built_ok_r   <= 1'b0;
			build_fail_r <= 1'b0;
		end
		else
		begin
			if (wr_bind)
			begin
				bind_act_r[bind_idx]  <= reg_wdata[fos_pkg::BIND_ACT];
				bind_slot_r[bind_idx] <=
					reg_wdata[fos_pkg::BIND_SLOT +: fos_pkg::SLOT_W];
			end
			if (wr_build)
			begin
				built_ok_r   <= !build_bad;
				build_fail_r <= build_bad;
				if (!build_bad)
				begin
					live_act_r  <= bind_act_r;
					live_slot_r <= bind_slot_r;
				end
			end
		end
	end

	// Coverage and fade as 0..256 so that full coverage is exact.
	wire logic [8:0] cov9  = {1'b0, in_frag.coverage}
		+ {8'h00, in_frag.coverage[7]};
	wire logic [8:0] fade9 = {1'b0, in_frag.fade}
		+ {8'h00, in_frag.fade[7]};
	wire logic [8:0] aa_k  = (in_frag.aa_en && !ci_mode)
		? cov9 : fos_pkg::SCALE_ONE;
	wire logic [8:0] fd_k  = (ms_en && in_frag.is_point && !ci_mode)
		? fade9 : fos_pkg::SCALE_ONE;

	fos_pkg::fos_out_s proc;

	genvar t;
	genvar k;
	generate
		for (t = 0; t < fos_pkg::NUM_TARGETS; t++)
		begin : g_tgt
			fos_pkg::fos_fmt_e fmt;
			fos_pkg::fos_vec_t src;
			logic              src_float;
			logic              hit;
			logic [fos_pkg::OUT_IDX_W-1:0] vidx;

			assign fmt = fos_pkg::fos_fmt_e'(fmt_r[2*t +: 2]);

			// Find the user output built onto this colour number.
			always_comb
			begin
				hit  = 1'b0;
				vidx = '0;
				for (int i = 0; i < fos_pkg::NUM_OUTS; i++)
					if (live_act_r[i] && int'(live_slot_r[i]) == t)
					begin
						hit  = 1'b1;
						vidx = fos_pkg::OUT_IDX_W'(i);
					end
			end

			// Unwritten colours simply carry whatever the source holds.
			wire logic use_vary = in_frag.src == fos_pkg::SRC_VARY
				&& hit && built_ok_r;
			assign src = use_vary ? in_frag.col[vidx]
				: (in_frag.src == fos_pkg::SRC_FINAL)
				? in_frag.col[0] : in_frag.col[t];
			assign src_float = use_vary
				? in_frag.is_float[vidx] : 1'b1;

			wire logic not_int = fmt != fos_pkg::FMT_INT;
			wire logic do_clamp = clamp_en && not_int && src_float;

			for (k = 0; k < 4; k++)
			begin : g_cmp
				logic [31:0] c0;
				logic [31:0] c1;
				logic [31:0] c2;
				logic [31:0] mag;
				assign c0 = do_clamp ? clamp01(src[k]) : src[k];
				// Scaling only ever touches alpha of non-integer targets.
				assign c1 = (k == 3 && not_int && src_float)
					? fscale(fscale(c0, aa_k), fd_k) : c0;
				assign mag = f2fix({1'b0, c1[30:0]},
					fmt == fos_pkg::FMT_SNORM
					? fos_pkg::SMAX : fos_pkg::UMAX);
				always_comb
				begin
					if (!src_float)
						c2 = src[k];
					else
						unique case (fmt)
							fos_pkg::FMT_UNORM:
								c2 = c1[31] ? 32'h0000_0000 : mag;
							fos_pkg::FMT_SNORM:
								c2 = c1[31] ? 32'(-mag) : mag;
							fos_pkg::FMT_FLOAT: c2 = c1;
							fos_pkg::FMT_INT:   c2 = src[k];
						endcase
				end
				assign proc.col[t][k] = ci_mode ? src[k] : c2;
			end
		end
	endgenerate

	// Depth path: shader depth only when the shader writes it statically.
	wire logic [31:0] dclamp = clamp01(in_frag.shader_depth);
	wire logic [31:0] dfix   = f2fix(dclamp, fos_pkg::DMAX);
	assign proc.depth = !in_frag.depth_written ? in_frag.raster_depth
		: d_float ? dclamp : dfix;

	// Index mode with antialiasing on puts the top coverage bits into the low index bits.
	assign proc.ci_index = (ci_mode && in_frag.aa_en)
		? {in_frag.ci_index[31:CI_BITS],
			in_frag.coverage[7 -: CI_BITS]}
		: in_frag.ci_index;

	// One register stage; ready is registered so a fragment waits a
	// cycle after each hand-off, trading half rate for a flop output.
	wire logic accept    = in_valid && ready_r;
	wire logic valid_nxt = accept ? 1'b1
		: (out_ready ? 1'b0 : valid_r);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid_r <= 1'b0;
			ready_r <= 1'b0;
			out_r   <= '0;
			count_r <= 32'h0000_0000;
		end
		else
		begin
			valid_r <= valid_nxt;
			ready_r <= !valid_nxt;
			if (accept)
			begin
				out_r   <= proc;
				count_r <= count_r + 32'h0000_0001;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign in_ready  = ready_r;
	assign out_valid = valid_r;
	assign out_frag  = out_r;

endmodule : fos_stage

// ---- tb/fos_stage_assertions.sv ----
// Port-level assertions of the fragment output stage.
`timescale 1ns/1ns
module fos_stage_assertions #(
	parameter int CI_BITS = fos_pkg::CI_COV_BITS
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	input wire logic               in_valid,
	input wire fos_pkg::fos_frag_s in_frag,
	input wire logic               in_ready,
	input wire logic               out_valid,
	input wire fos_pkg::fos_out_s  out_frag,
	input wire logic               out_ready
);
	logic [3:0] ctrl_r;
	logic [1:0] fmt0_r;
	logic       take;
	logic       go;
	assign take = in_valid && in_ready;
	assign go = take && in_frag.src == fos_pkg::SRC_DATA && !ctrl_r[1];
	// Shadows of control and target 0 format, since only ports are seen.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= 4'h1;
			fmt0_r <= 2'h0;
		end
		else if (reg_wr && reg_addr == fos_pkg::REG_CTRL)
			ctrl_r <= reg_wdata[3:0];
		else if (reg_wr && reg_addr == fos_pkg::REG_FMT)
			fmt0_r <= reg_wdata[1:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	hold_stall_a: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_frag))
		else $error("result changed under stall");
	block_full_a: assert property (out_valid |-> !in_ready)
		else $error("input open while result held");
	take_out_a: assert property (take |=> out_valid && !in_ready)
		else $error("taken fragment not presented");
	raster_depth_a: assert property (
		take && !in_frag.depth_written
		|=> out_frag.depth == $past(in_frag.raster_depth))
		else $error("raster depth not forwarded");
	float_clamp_a: assert property (
		go && in_frag.is_float[0] && ctrl_r[0] && fmt0_r == 2'h2
		|=> out_frag.col[0][0] <= fos_pkg::FP_ONE)
		else $error("float colour above one");
	raw_pass_a: assert property (
		go && (fmt0_r == 2'h3 || !ctrl_r[0] && fmt0_r == 2'h2)
		|=> out_frag.col[0][0] == $past(in_frag.col[0][0]))
		else $error("colour modified");
	int_alpha_a: assert property (
		go && fmt0_r == 2'h3
		|=> out_frag.col[0][3] == $past(in_frag.col[0][3]))
		else $error("integer alpha modified");
	ci_cov_a: assert property (
		take && ctrl_r[1] && in_frag.aa_en
		|=> out_frag.ci_index[CI_BITS-1:0]
			== $past(in_frag.coverage[7 -: CI_BITS]))
		else $error("coverage not in index");
	stall_c: cover property (out_valid && !out_ready);
	ci_c: cover property (take && ctrl_r[1]);
	clamp_c: cover property (go && ctrl_r[0]);
endmodule : fos_stage_assertions

// ---- tb/fos_src.sv ----
// Upstream fragment source model feeding the output stage.
`timescale 1ns/1ns
module fos_src (
	input  wire logic          clk,
	input  wire logic          in_ready,
	output fos_pkg::fos_frag_s in_frag,
	output logic               in_valid
);
	initial
	begin
		in_valid = 1'b0;
		in_frag  = '0;
	end
	// After hand-off the inverse is shown, so stale data never looks live.
	task send(input fos_pkg::fos_frag_s f, input int gap);
		repeat (gap) @(posedge clk);
		in_valid <= 1'b1;
		in_frag  <= f;
		do
			@(negedge clk);
		while (!in_ready);
		@(posedge clk);
		in_valid <= 1'b0;
		in_frag  <= ~f;
	endtask : send
endmodule : fos_src

// ---- tb/testbench.sv ----
// Self-checking bench of the fragment output stage.
`timescale 1ns/1ns
module testbench;
	typedef struct packed {
		logic [3:0]  ctrl;
		logic [1:0]  fmt;
		logic [31:0] x;
		logic        aa;
		logic        pt;
		logic [7:0]  cf;
		logic        dw;
		logic [31:0] sd;
		logic [31:0] er;
		logic [31:0] ea;
		logic [31:0] ed;
	} fos_row_s;
	localparam logic [31:0] F1 = 32'h3F80_0000, F2 = 32'h4000_0000,
		FN = 32'hBF80_0000, FF = 32'hFF, Z = 32'h0, RD = 32'h123,
		DM = 32'hFF_FFFF, SM = 32'h7F;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic [7:0]         reg_addr = 8'h0;
	logic [31:0]        reg_wdata = 32'h0;
	logic [31:0]        reg_rdata, d;
	logic               reg_wr = 1'b0, reg_rd = 1'b0, out_ready = 1'b1;
	logic               in_valid, in_ready, out_valid;
	fos_pkg::fos_frag_s in_frag, f;
	fos_pkg::fos_out_s  out_frag, o;
	int                 error_cnt = 0, n_tests = 0, nfr = 0;
	fos_row_s           rows [13];
	always #4 clk = ~clk;
	fos_stage u_fos_stage (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_valid(in_valid), .in_frag(in_frag),
		.in_ready(in_ready), .out_valid(out_valid), .out_frag(out_frag),
		.out_ready(out_ready));
	fos_src u_fos_src (.clk(clk), .in_ready(in_ready), .in_frag(in_frag),
		.in_valid(in_valid));
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
		@(posedge clk);
	endtask : rd
	task xfer(input fos_pkg::fos_frag_s g);
		u_fos_src.send(g, 0);
		nfr++;
		@(negedge clk);
		chk({31'h0, out_valid}, 32'h1);
		o = out_frag;
		@(posedge clk);
	endtask : xfer
	function automatic fos_pkg::fos_frag_s mk(input fos_row_s r);
		fos_pkg::fos_frag_s g;
		g = '0;
		g.col = {32{r.x}};
		g.is_float = 8'hFF;
		g.src = fos_pkg::SRC_DATA;
		g.depth_written = r.dw;
		g.shader_depth = r.sd;
		g.raster_depth = RD;
		g.aa_en = r.aa;
		g.is_point = r.pt;
		g.coverage = r.cf;
		g.fade = r.cf;
		return g;
	endfunction : mk
	initial
	begin
		#100000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		rows = '{'{4'h1, 2'h0, F1, 1'b0, 1'b0, 8'h00, 1'b0, F2, FF, FF, RD},
			'{4'h1, 2'h0, F2, 1'b0, 1'b0, 8'h00, 1'b1, F2, FF, FF, DM},
			'{4'h1, 2'h0, FN, 1'b0, 1'b0, 8'h00, 1'b1, FN, Z, Z, Z},
			'{4'h1, 2'h1, F1, 1'b0, 1'b0, 8'h00, 1'b1, F1, SM, SM, DM},
			'{4'h9, 2'h2, F2, 1'b0, 1'b0, 8'h00, 1'b1, F2, F1, F1, F1},
			'{4'h8, 2'h2, F2, 1'b0, 1'b0, 8'h00, 1'b1, FN, F2, F2, Z},
			'{4'h1, 2'h3, F2, 1'b0, 1'b0, 8'h00, 1'b0, Z, F2, F2, RD},
			'{4'h1, 2'h0, F1, 1'b1, 1'b0, 8'h00, 1'b0, Z, FF, Z, RD},
			'{4'h1, 2'h0, F1, 1'b1, 1'b0, 8'hFF, 1'b0, Z, FF, FF, RD},
			'{4'h5, 2'h0, F1, 1'b0, 1'b1, 8'h00, 1'b0, Z, FF, Z, RD},
			'{4'h1, 2'h0, F1, 1'b0, 1'b1, 8'h00, 1'b0, Z, FF, FF, RD},
			'{4'h1, 2'h3, F1, 1'b1, 1'b0, 8'h00, 1'b0, Z, F1, F1, RD},
			'{4'h5, 2'h2, F1, 1'b0, 1'b1, 8'h00, 1'b0, Z, F1, Z, RD}};
		repeat (2) @(posedge clk);
		chk({31'h0, in_ready}, Z);
		chk({31'h0, out_valid}, Z);
		rst_n <= 1'b1;
		rd(fos_pkg::REG_CTRL, d);
		chk(d, fos_pkg::CTRL_RST);
		rd(fos_pkg::REG_FMT, d);
		chk(d, fos_pkg::FMT_RST);
		rd(fos_pkg::REG_FBSEL, d);
		chk(d, fos_pkg::FBSEL_RST);
		rd(fos_pkg::REG_QUERY, d);
		chk(d, fos_pkg::NO_SLOT);
		rd(8'h1C, d);
		chk(d, Z);
		$display("reset test done");
		for (int i = 0; i < 13; i++)
		begin
			wr(fos_pkg::REG_CTRL, {28'h0, rows[i].ctrl});
			wr(fos_pkg::REG_FMT, {24'h0, {4{rows[i].fmt}}});
			xfer(mk(rows[i]));
			chk(o.col[0][0], rows[i].er);
			chk(o.col[3][3], rows[i].ea);
			chk(o.depth, rows[i].ed);
			$display("row %0d done", i);
		end
		for (int i = 0; i < 4; i++)
			wr(fos_pkg::REG_BIND, 32'h100 + 32'((3 - i) * 16 + i));
		wr(fos_pkg::REG_BUILD, Z);
		rd(fos_pkg::REG_BUILD, d);
		chk(d, 32'h1);
		wr(fos_pkg::REG_QUERY, 32'h1);
		rd(fos_pkg::REG_QUERY, d);
		chk(d, 32'h2);
		wr(fos_pkg::REG_QUERY, 32'h5);
		rd(fos_pkg::REG_QUERY, d);
		chk(d, fos_pkg::NO_SLOT);
		wr(fos_pkg::REG_FMT, 32'h0000_0000);
		f = '0;
		f.src = fos_pkg::SRC_VARY;
		for (int t = 0; t < 4; t++)
			f.col[t][0] = 32'(t + 16);
		xfer(f);
		chk(o.col[0][0], 32'h13);
		chk(o.col[3][0], 32'h10);
		wr(fos_pkg::REG_BIND, 32'h104);
		wr(fos_pkg::REG_BUILD, Z);
		rd(fos_pkg::REG_BUILD, d);
		chk(d, 32'h2);
		wr(fos_pkg::REG_QUERY, 32'h1);
		rd(fos_pkg::REG_QUERY, d);
		chk(d, fos_pkg::NO_SLOT);
		wr(fos_pkg::REG_BIND, 32'h004);
		wr(fos_pkg::REG_BIND, 32'h133);
		wr(fos_pkg::REG_BUILD, Z);
		rd(fos_pkg::REG_BUILD, d);
		chk(d, 32'h2);
		wr(fos_pkg::REG_BIND, 32'h140);
		wr(fos_pkg::REG_BUILD, Z);
		rd(fos_pkg::REG_BUILD, d);
		chk(d, 32'h2);
		$display("build test done");
		wr(fos_pkg::REG_CTRL, 32'h1);
		wr(fos_pkg::REG_FMT, 32'hC);
		f = '0;
		f.src = fos_pkg::SRC_DATA;
		f.is_float = 8'hFE;
		f.col[0][0] = F2;
		f.col[2][0] = F2;
		xfer(f);
		chk(o.col[0][0], FF);
		chk(o.col[2][0], FF);
		f.src = fos_pkg::SRC_FINAL;
		f.is_float = 8'hFF;
		f.col[0] = {4{F1}};
		f.aa_en = 1'b1;
		xfer(f);
		chk(o.col[3][0], FF);
		chk(o.col[0][3], Z);
		chk(o.col[1][3], F1);
		$display("route test done");
		wr(fos_pkg::REG_CTRL, 32'h7);
		f.is_point = 1'b1;
		f.coverage = 8'h5F;
		f.ci_index = 32'hAB0;
		xfer(f);
		chk(o.ci_index, 32'hAB5);
		chk(o.col[0][3], F1);
		$display("index test done");
		wr(fos_pkg::REG_CTRL, 32'h1);
		out_ready <= 1'b0;
		u_fos_src.send(f, 3);
		nfr++;
		repeat (3) @(negedge clk);
		chk({31'h0, out_valid}, 32'h1);
		chk({31'h0, in_ready}, Z);
		@(posedge clk);
		out_ready <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, out_valid}, Z);
		@(posedge clk);
		rd(fos_pkg::REG_COUNT, d);
		chk(d, 32'(nfr));
		$display("stall test done");
		report_and_stop();
	end
endmodule : testbench
bind fos_stage fos_stage_assertions #(.CI_BITS(CI_BITS))
	u_fos_stage_assertions (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .in_valid(in_valid), .in_frag(in_frag),
	.in_ready(in_ready), .out_valid(out_valid), .out_frag(out_frag),
	.out_ready(out_ready));
